/* core/tmr8_pkg.sv */
/*
  Constants, mode codes and carrier structs for the 8-bit timer/counter
  with two compare channels.
  Assumes a single 200 MHz core clock and plain control ports.
*/
package tmr8_pkg;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hff;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMPA = 3'h5;
  localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam int unsigned FLAG_OVF = 0;
  localparam int unsigned FLAG_CMPA = 1;
  localparam int unsigned FLAG_CMPB = 2;

  typedef struct packed {
    logic [2:0] waveform_mode_field;
    logic [2:0] clock_select_field;
    logic async_clock_select;
    logic timer_power_reduction;
  } tmr8_ctrl_s;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } tmr8_wr_s;
endpackage

/* core/tmr8_timer.sv */
/*
  8-bit up/down timer/counter with two compare channels, flags and masks.
  Assumes tick sources are one-cycle pulses synchronous to core_clk, that
  the oscillator tick is already brought into this domain, and that the
  prescaler lives outside and delivers its chosen tick on io_tick.
*/
// Contract
// - Counter and compares are 8-bit; bidirectional counter.
// - BOTTOM 0x00, MAX 0xFF, TOP by mode.
// - Tick from I/O clock, else oscillator.
// - Clock select zero stops the counter.
// - CPU may access counter anytime; counter writes are ignored while the power-reduction bit is set.
// - CPU counter write beats hardware update.
// - Each tick clears, increments or decrements.
// - Three-bit waveform mode selects sequence.
// - Overflow flag set per mode; interrupts.
// - Comparator signals equality continuously.
// - Match sets flag at next tick.
// - Flag clears on service or write-one.
// - Flags visible, each masked separately.
// - Compares buffered only in PWM modes.
// - Buffer copies only at top/bottom.
// - CPU writes buffer or active register.
// - Force strobe updates output in non-PWM modes only, nothing else.
// - Counter write blocks matches next tick.
// - Output state survives mode changes.
// - Output mode bits act immediately.
// - Power-reduction bit disables the module.
// - Normal mode wraps, overflow at zero.
module tmr8_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire tmr8_pkg::tmr8_ctrl_s ctrl,
  input wire logic io_tick,
  input wire logic osc_tick,
  input wire tmr8_pkg::tmr8_wr_s cnt_wr,
  input wire tmr8_pkg::tmr8_wr_s cmpa_wr,
  input wire tmr8_pkg::tmr8_wr_s cmpb_wr,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [1:0] compare_output_mode_b,
  input wire logic [1:0] force_compare_strobe,
  input wire logic [2:0] flag_clear,
  input wire logic [2:0] flag_ack,
  input wire logic [2:0] timer_mask_register,
  output logic [7:0] counter_value,
  output logic [7:0] compare_value_a,
  output logic [7:0] compare_value_b,
  output logic [2:0] timer_flag_register,
  output logic [2:0] irq,
  output logic compare_output_a,
  output logic compare_output_b
);
  // ----------------------------------------
  // Mode decode and tick selection
  // ----------------------------------------
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] ocr_reg [2];
  logic [7:0] buf_reg [2];
  logic oc_reg [2];
  logic [2:0] flag_reg;
  logic [2:0] flag_next;
  logic [2:0] irq_reg;
  logic [2:0] irq_next;
  logic down_reg;
  logic block_reg;
  logic block_next;
  logic [1:0] match_dly_reg;
  logic [1:0] match_dly_next;
  logic [7:0] shadow_a_reg;
  logic [7:0] shadow_b_reg;

  wire logic [2:0] wgm = ctrl.waveform_mode_field;
  wire logic enabled = !ctrl.timer_power_reduction;
  wire logic src_tick = ctrl.async_clock_select ? osc_tick : io_tick;
  wire logic tick = enabled && (ctrl.clock_select_field != tmr8_pkg::CS_STOP)
    && src_tick;
  wire logic phase_correct = (wgm == tmr8_pkg::WGM_PC_MAX) || (wgm == tmr8_pkg::WGM_PC_CMPA);
  wire logic fast_pwm = (wgm == tmr8_pkg::WGM_FAST_MAX) || (wgm == tmr8_pkg::WGM_FAST_CMPA);
  wire logic pwm = phase_correct || fast_pwm;
  wire logic top_is_cmpa = (wgm == tmr8_pkg::WGM_CTC) || (wgm == tmr8_pkg::WGM_PC_CMPA)
    || (wgm == tmr8_pkg::WGM_FAST_CMPA);
  wire logic [7:0] top_val = top_is_cmpa ? ocr_reg[0] : tmr8_pkg::MAX_VAL;
  wire logic at_top = (cnt_reg == top_val);
  wire logic at_bottom = (cnt_reg == tmr8_pkg::BOTTOM_VAL);
  wire logic at_max = (cnt_reg == tmr8_pkg::MAX_VAL);

  // ----------------------------------------
  // Counter sequence
  // ----------------------------------------
  wire logic dir_down = phase_correct && (at_top ? 1'b1 : (at_bottom ? 1'b0 : down_reg));
  always_comb
  begin
    cnt_next = cnt_reg;
    if (tick)
    begin
      if ((wgm == tmr8_pkg::WGM_CTC || fast_pwm) && at_top)
        cnt_next = tmr8_pkg::BOTTOM_VAL;
      else if (dir_down)
        cnt_next = cnt_reg - 8'h01;
      else
        cnt_next = cnt_reg + 8'h01;
    end
    if (cnt_wr.wr)
      cnt_next = cnt_wr.data;
  end

  // ----------------------------------------
  // Compare, update points and flag events
  // ----------------------------------------
  wire logic [1:0] match = {cnt_reg == ocr_reg[1], cnt_reg == ocr_reg[0]};
  wire logic upd_point = phase_correct ? at_top : (fast_pwm && at_bottom);
  wire logic upd_now = tick && pwm && upd_point;
  wire logic ovf_ev = tick && (phase_correct ? at_bottom : (fast_pwm ? at_top : at_max));
  wire logic [1:0] hit = tick ? match_dly_reg : 2'b00;
  wire logic [2:0] flag_set = {hit, ovf_ev};
  wire logic [2:0] flag_drop = flag_clear | flag_ack;
  wire logic [1:0] com [2];
  assign com[0] = compare_output_mode_a;
  assign com[1] = compare_output_mode_b;
  wire tmr8_pkg::tmr8_wr_s cw [2];
  assign cw[0] = cmpa_wr;
  assign cw[1] = cmpb_wr;

  // ----------------------------------------
  // Flag, interrupt and match blocking next state
  // ----------------------------------------
  always_comb
  begin
    flag_next = flag_set | (flag_reg & ~flag_drop);
    irq_next = flag_next & timer_mask_register;
    match_dly_next = match_dly_reg;
    if (tick)
      match_dly_next = block_reg ? 2'b00 : match;
    block_next = block_reg;
    if (cnt_wr.wr)
      block_next = 1'b1;
    else if (tick)
      block_next = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= tmr8_pkg::CNT_RST;
      down_reg <= 1'b0;
      block_reg <= 1'b0;
      match_dly_reg <= 2'b00;
      flag_reg <= 3'h0;
      irq_reg <= 3'h0;
    end
    else if (enabled)
    begin
      cnt_reg <= cnt_next;
      if (tick)
        down_reg <= dir_down;
      block_reg <= block_next;
      match_dly_reg <= match_dly_next;
      flag_reg <= flag_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // Per-channel compare registers and output state
  // ----------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    wire logic force_ok = !pwm && force_compare_strobe[ch];
    wire logic real_hit = hit[ch];
    wire logic fire = force_ok || (!pwm && real_hit);
    wire logic direct_wr = cw[ch].wr && !pwm;
    logic oc_pwm;
    logic oc_fire;
    logic oc_next;
    logic [7:0] ocr_next;
    logic [7:0] buf_next;
    always_comb
    begin
      oc_pwm = oc_reg[ch];
      if (fast_pwm && tick && at_bottom)
        oc_pwm = (com[ch] == tmr8_pkg::COM_SET) ? 1'b0 : 1'b1;
      if (pwm && real_hit)
      begin
        if (com[ch] == tmr8_pkg::COM_CLEAR)
          oc_pwm = phase_correct ? !down_reg : 1'b0;
        else if (com[ch] == tmr8_pkg::COM_SET)
          oc_pwm = phase_correct ? down_reg : 1'b1;
      end
    end
    always_comb
    begin
      oc_fire = oc_reg[ch];
      unique case (com[ch])
        tmr8_pkg::COM_NONE: oc_fire = oc_reg[ch];
        tmr8_pkg::COM_TOGGLE: oc_fire = !oc_reg[ch];
        tmr8_pkg::COM_CLEAR: oc_fire = 1'b0;
        tmr8_pkg::COM_SET: oc_fire = 1'b1;
      endcase
    end
    always_comb
    begin
      oc_next = oc_reg[ch];
      if (fire)
        oc_next = oc_fire;
      else if (com[ch] != tmr8_pkg::COM_NONE)
        oc_next = oc_pwm;
      buf_next = buf_reg[ch];
      if (cw[ch].wr)
        buf_next = cw[ch].data;
      ocr_next = ocr_reg[ch];
      if (direct_wr)
        ocr_next = cw[ch].data;
      else if (upd_now)
        ocr_next = buf_reg[ch];
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ocr_reg[ch] <= tmr8_pkg::CMP_RST;
        buf_reg[ch] <= tmr8_pkg::CMP_RST;
        oc_reg[ch] <= 1'b0;
      end
      else if (enabled)
      begin
        buf_reg[ch] <= buf_next;
        ocr_reg[ch] <= ocr_next;
        oc_reg[ch] <= oc_next;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shadow_a_reg <= tmr8_pkg::CMP_RST;
      shadow_b_reg <= tmr8_pkg::CMP_RST;
    end
    else
    begin
      shadow_a_reg <= pwm ? buf_reg[0] : ocr_reg[0];
      shadow_b_reg <= pwm ? buf_reg[1] : ocr_reg[1];
    end
  end

  assign counter_value = cnt_reg;
  assign compare_value_a = shadow_a_reg;
  assign compare_value_b = shadow_b_reg;
  assign timer_flag_register = flag_reg;
  assign irq = irq_reg;
  assign compare_output_a = oc_reg[0];
  assign compare_output_b = oc_reg[1];
endmodule

/* dv/tmr8_sva.sv */
/*
  Port assertions for the 8-bit timer/counter.
  Assumes one clock core_clk and an asynchronous active-low rst_n.
*/
module tmr8_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire tmr8_pkg::tmr8_ctrl_s ctrl,
  input wire logic io_tick,
  input wire logic osc_tick,
  input wire tmr8_pkg::tmr8_wr_s cnt_wr,
  input wire logic [2:0] flag_clear,
  input wire logic [2:0] flag_ack,
  input wire logic [1:0] force_compare_strobe,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [2:0] timer_mask_register,
  input wire logic [7:0] counter_value,
  input wire logic [2:0] timer_flag_register,
  input wire logic [2:0] irq,
  input wire logic compare_output_a
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic tk = ctrl.async_clock_select ? osc_tick : io_tick;
  wire logic on0 = !ctrl.timer_power_reduction && ctrl.waveform_mode_field == 3'h0;
  wire logic run = tk && ctrl.clock_select_field != 3'h0 && on0 && !cnt_wr.wr;
  cnt_write_a:
    assert property (cnt_wr.wr && !ctrl.timer_power_reduction |=> counter_value == $past(cnt_wr.data))
    else $error("counter write lost");
  stop_hold_a:
    assert property (ctrl.clock_select_field == 3'h0 && !cnt_wr.wr |=> $stable(counter_value))
    else $error("stopped counter moved");
  count_up_a:
    assert property (run && counter_value != 8'hff |=> counter_value == $past(counter_value) + 8'h01)
    else $error("counter did not step");
  wrap_ovf_a:
    assert property (run && counter_value == 8'hff |=> counter_value == 8'h00 && timer_flag_register[0])
    else $error("wrap or overflow wrong");
  irq_follow_a:
    assert property (timer_flag_register[0] && timer_mask_register[0] && !flag_clear[0]
      && !flag_ack[0] && !ctrl.timer_power_reduction |=> irq[0])
    else $error("irq missing");
  flag_clear_a:
    assert property (flag_clear[0] && on0 && !tk |=> !timer_flag_register[0])
    else $error("flag not cleared");
  power_off_a:
    assert property (ctrl.timer_power_reduction |=> $stable(counter_value) && $stable(timer_flag_register))
    else $error("disabled timer changed");
  force_clear_a:
    assert property (force_compare_strobe[0] && on0 && compare_output_mode_a == 2'h2 |=> !compare_output_a)
    else $error("forced clear failed");
endmodule
bind tmr8_timer tmr8_sva sva_i (.core_clk(core_clk), .rst_n(rst_n), .ctrl(ctrl),
  .io_tick(io_tick), .osc_tick(osc_tick), .cnt_wr(cnt_wr), .flag_clear(flag_clear),
  .flag_ack(flag_ack),
  .force_compare_strobe(force_compare_strobe), .compare_output_mode_a(compare_output_mode_a),
  .timer_mask_register(timer_mask_register), .counter_value(counter_value),
  .timer_flag_register(timer_flag_register), .irq(irq), .compare_output_a(compare_output_a));

/* dv/tb_tmr8_timer.sv */
/*
  Self-checking bench for the 8-bit timer/counter.
  Assumes the checker in tmr8_sva.sv is bound to the design.
*/
module tb_tmr8_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, io_tick = 1'b0, osc_tick = 1'b0, oca, ocb;
  tmr8_pkg::tmr8_ctrl_s ctrl = '0;
  tmr8_pkg::tmr8_wr_s cnt_wr = '0, cmpa_wr = '0, cmpb_wr = '0;
  logic [1:0] com_a = 2'h0, fstb = 2'h0;
  logic [2:0] fclr = 3'h0, fack = 3'h0, mask = 3'h1, flags, irq;
  logic [7:0] cnt, cva, cvb;
  int mismatches = 0, n_checks = 0, cyc = 0;
  tmr8_timer dut (.core_clk(core_clk), .rst_n(rst_n), .ctrl(ctrl), .io_tick(io_tick),
    .osc_tick(osc_tick), .cnt_wr(cnt_wr), .cmpa_wr(cmpa_wr), .cmpb_wr(cmpb_wr),
    .compare_output_mode_a(com_a), .compare_output_mode_b(2'h0), .force_compare_strobe(fstb),
    .flag_clear(fclr), .flag_ack(fack), .timer_mask_register(mask), .counter_value(cnt),
    .compare_value_a(cva), .compare_value_b(cvb), .timer_flag_register(flags), .irq(irq),
    .compare_output_a(oca), .compare_output_b(ocb));
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic ticks(input int n, input logic osc);
    io_tick = !osc;
    osc_tick = osc;
    cyc_n(n);
    io_tick = 1'b0;
    osc_tick = 1'b0;
  endtask
  task automatic wr_cnt(input logic [7:0] d);
    cnt_wr = '{1'b1, d};
    cyc_n(1);
    cnt_wr.wr = 1'b0;
  endtask
  task automatic force_a();
    fstb = 2'h1;
    cyc_n(1);
    fstb = 2'h0;
    cyc_n(1);
  endtask
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 1000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    cyc_n(5);
    rst_n = 1'b1;
    cyc_n(1);
    chk(cnt, 8'h00);
    wr_cnt(8'hfe);
    ticks(3, 1'b0);
    chk(cnt, 8'hfe);
    ctrl.clock_select_field = 3'h1;
    cmpa_wr = '{1'b1, 8'h05};
    cmpb_wr = '{1'b1, 8'h80};
    cyc_n(1);
    cmpa_wr.wr = 1'b0;
    cmpb_wr.wr = 1'b0;
    cyc_n(1);
    chk(cva, 8'h05);
    chk(cvb, 8'h80);
    ticks(2, 1'b0);
    chk(cnt, 8'h00);
    chk(flags, 8'h01);
    cyc_n(1);
    chk(irq, 8'h01);
    fclr = 3'h1;
    cyc_n(1);
    fclr = 3'h0;
    chk(flags, 8'h00);
    wr_cnt(8'h05);
    ticks(2, 1'b0);
    chk(flags, 8'h00);
    wr_cnt(8'h03);
    ticks(4, 1'b0);
    chk(flags, 8'h02);
    chk(cnt, 8'h07);
    com_a = tmr8_pkg::COM_TOGGLE;
    force_a();
    chk(oca, 8'h01);
    ctrl.waveform_mode_field = tmr8_pkg::WGM_FAST_MAX;
    force_a();
    chk(oca, 8'h01);
    ctrl.waveform_mode_field = tmr8_pkg::WGM_NORMAL;
    com_a = tmr8_pkg::COM_CLEAR;
    force_a();
    chk(oca, 8'h00);
    chk(flags, 8'h02);
    fack = 3'h2;
    cyc_n(1);
    fack = 3'h0;
    chk(flags, 8'h00);
    chk(ocb, 8'h00);
    ctrl.async_clock_select = 1'b1;
    ticks(3, 1'b0);
    chk(cnt, 8'h07);
    ticks(2, 1'b1);
    chk(cnt, 8'h09);
    ctrl.timer_power_reduction = 1'b1;
    wr_cnt(8'h42);
    chk(cnt, 8'h09);
    close_out();
  end
endmodule
